// ===== common/anpr_pkg.sv
/*
 * Package for the auto-negotiation page register bank: register indices,
 * field positions, reset values and the structs that carry pages.
 * Assumes a 16-bit management register space addressed by a 5-bit index.
 */
package anpr_pkg;

    localparam logic [4:0] ADDR_ADVERT = 5'h04;
    localparam logic [4:0] ADDR_PARTNER = 5'h05;
    localparam logic [4:0] ADDR_EXPANSION = 5'h06;
    localparam logic [4:0] ADDR_NP_TX = 5'h07;
    localparam logic [4:0] ADDR_NP_RX = 5'h08;

    localparam int BIT_NP = 15;
    localparam int BIT_ACK = 14;
    localparam int BIT_RF_HI = 13;
    localparam int BIT_RF_LO = 12;
    localparam int BIT_PAUSE_HI = 8;
    localparam int BIT_PAUSE_LO = 7;
    localparam int BIT_HD = 6;
    localparam int BIT_FD = 5;
    localparam int BIT_NP_ABLE = 2;
    localparam int BIT_PAGE_RX = 1;
    localparam int BIT_MSG_PAGE = 13;
    localparam int BIT_ACK2 = 12;
    localparam int BIT_TOGGLE = 11;
    localparam int BIT_CODE_HI = 10;

    localparam logic [1:0] RF_NO_ERROR = 2'h0;
    localparam logic [1:0] RST_PAUSE = 2'h3;
    localparam logic RST_FD = 1'b1;
    localparam logic RST_NP_MORE = 1'b0;
    localparam logic RST_MSG_PAGE = 1'b1;
    localparam logic RST_ACK2 = 1'b0;
    localparam logic [10:0] RST_CODE = 11'h001;
    localparam logic NP_ABLE_VALUE = 1'b1;

    // Local advertisement fields that software may change.
    typedef struct packed {
        logic [1:0] remote_fault;
        logic [1:0] pause;
        logic full_duplex;
    } anpr_advert_t;

    // Received base page as delivered by the negotiation function.
    typedef struct packed {
        logic next_page;
        logic ack;
        logic [1:0] remote_fault;
        logic [1:0] pause;
        logic half_duplex;
        logic full_duplex;
    } anpr_base_t;

    // Next page, transmitted or received.
    typedef struct packed {
        logic more;
        logic ack;
        logic msg_page;
        logic ack2;
        logic toggle;
        logic [10:0] code;
    } anpr_npage_t;

endpackage

// ===== rtl/anpr_page_capture.sv
/*
 * Holding register for one page word loaded by the negotiation function.
 * Assumes the load strobe is a single-cycle pulse on core_clk_i.
 */
`timescale 1ns/1ps
module anpr_page_capture #(
    parameter int WIDTH = 16
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] data_i,
    output logic [WIDTH-1:0] data_o
);

    logic [WIDTH-1:0] data_ff;
    logic [WIDTH-1:0] nxt_data;

    always_comb
    begin
        nxt_data = data_ff;
        if (load_i)
        begin
            nxt_data = data_i;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            data_ff <= '0;
        end
        else
        begin
            data_ff <= nxt_data;
        end
    end

    assign data_o = data_ff;

endmodule

// ===== rtl/anpr_regs.sv
/*
 * Auto-negotiation page register bank: local advertisement, partner base
 * page, expansion flags and next page transmit and receive.
 * Assumes management accesses arrive as one-cycle read and write strobes
 * with a 5-bit register index, and that the negotiation function drives
 * its load and event strobes synchronously on core_clk_i.
 */
// Operation
// - Advertised next-page bit reads zero and ignores writes.
// - Advertised pause field is writable, resets to both symmetric and asymmetric.
// - Advertised half duplex bit always reads zero.
// - Advertised full duplex bit is writable and resets to one.
// - Reserved advertisement bits read zero; writes to them do nothing.
// - Partner base page is read-only, resets to zero, reports received fields.
// - Partner acknowledge bit is read-only, set by the negotiation function.
// - Partner duplex bits report received abilities, one meaning supported.
// - Expansion next-page-able bit always reads one.
// - Page received flag sets on a new page, clears when expansion is read.
// - Next page transmit has more-pages, message-page and comply bits with resets.
// - Transmit toggle is read-only and alternates between successive pages sent.
// - Eleven-bit transmit code is writable and resets to the null message.
// - Without next page support the transmit register returns its defaults.
// - Next page receive is read-only, resets to zero, reports partner page.
// - Advertisement may also be loaded from the configuration input.
// - Undefined addresses read zero and are read-only.
`timescale 1ns/1ps
module anpr_regs #(
    parameter bit NEXT_PAGE_EN = 1'b0
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic mgmt_wr_i,
    input wire logic mgmt_rd_i,
    input wire logic [4:0] mgmt_addr_i,
    input wire logic [15:0] mgmt_wdata_i,
    output logic [15:0] mgmt_rdata_o,
    input wire logic cfg_load_i,
    input wire anpr_pkg::anpr_advert_t cfg_advert_i,
    input wire logic an_complete_i,
    input wire logic base_load_i,
    input wire anpr_pkg::anpr_base_t base_page_i,
    input wire logic np_rx_load_i,
    input wire anpr_pkg::anpr_npage_t np_rx_page_i,
    input wire logic np_tx_sent_i,
    output anpr_pkg::anpr_advert_t advert_o,
    output anpr_pkg::anpr_npage_t np_tx_page_o
);

    anpr_pkg::anpr_advert_t advert_ff;
    anpr_pkg::anpr_advert_t nxt_advert;
    logic np_more_ff;
    logic nxt_np_more;
    logic np_msg_ff;
    logic nxt_np_msg;
    logic np_ack2_ff;
    logic nxt_np_ack2;
    logic [10:0] np_code_ff;
    logic [10:0] nxt_np_code;
    logic np_toggle_ff;
    logic nxt_np_toggle;
    logic page_rx_ff;
    logic nxt_page_rx;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic [15:0] partner_word;
    logic [15:0] np_rx_word;
    logic [15:0] np_tx_word;
    logic [15:0] base_in_word;
    logic [15:0] np_in_word;
    logic wr_advert;
    logic wr_np_tx;

    assign wr_advert = mgmt_wr_i && (mgmt_addr_i == anpr_pkg::ADDR_ADVERT);
    assign wr_np_tx = mgmt_wr_i && (mgmt_addr_i == anpr_pkg::ADDR_NP_TX) && NEXT_PAGE_EN;

    // Received pages are packed into register layout before capture.
    always_comb
    begin
        base_in_word = '0;
        base_in_word[anpr_pkg::BIT_NP] = base_page_i.next_page;
        base_in_word[anpr_pkg::BIT_ACK] = base_page_i.ack;
        base_in_word[anpr_pkg::BIT_RF_HI:anpr_pkg::BIT_RF_LO] = base_page_i.remote_fault;
        base_in_word[anpr_pkg::BIT_PAUSE_HI:anpr_pkg::BIT_PAUSE_LO] = base_page_i.pause;
        base_in_word[anpr_pkg::BIT_HD] = base_page_i.half_duplex;
        base_in_word[anpr_pkg::BIT_FD] = base_page_i.full_duplex;
        np_in_word = '0;
        np_in_word[anpr_pkg::BIT_NP] = np_rx_page_i.more;
        np_in_word[anpr_pkg::BIT_ACK] = np_rx_page_i.ack;
        np_in_word[anpr_pkg::BIT_MSG_PAGE] = np_rx_page_i.msg_page;
        np_in_word[anpr_pkg::BIT_ACK2] = np_rx_page_i.ack2;
        np_in_word[anpr_pkg::BIT_TOGGLE] = np_rx_page_i.toggle;
        np_in_word[anpr_pkg::BIT_CODE_HI:0] = np_rx_page_i.code;
    end

    // Only the negotiation function loads these; software has no write path.
    anpr_page_capture #(
        .WIDTH(16)
    ) u_partner (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .load_i(base_load_i),
        .data_i(base_in_word),
        .data_o(partner_word)
    );

    anpr_page_capture #(
        .WIDTH(16)
    ) u_np_rx (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .load_i(np_rx_load_i),
        .data_i(np_in_word),
        .data_o(np_rx_word)
    );

    // Advertisement: configuration load wins over a management write in the same cycle.
    always_comb
    begin
        nxt_advert = advert_ff;
        if (wr_advert)
        begin
            nxt_advert.remote_fault = mgmt_wdata_i[anpr_pkg::BIT_RF_HI:anpr_pkg::BIT_RF_LO];
            nxt_advert.pause = mgmt_wdata_i[anpr_pkg::BIT_PAUSE_HI:anpr_pkg::BIT_PAUSE_LO];
            nxt_advert.full_duplex = mgmt_wdata_i[anpr_pkg::BIT_FD];
        end
        if (cfg_load_i)
        begin
            nxt_advert = cfg_advert_i;
        end
        if (an_complete_i)
        begin
            nxt_advert.remote_fault = anpr_pkg::RF_NO_ERROR;
        end
    end

    // Next page transmit; writes only land when next page support is built in.
    always_comb
    begin
        nxt_np_more = np_more_ff;
        nxt_np_msg = np_msg_ff;
        nxt_np_ack2 = np_ack2_ff;
        nxt_np_code = np_code_ff;
        nxt_np_toggle = np_toggle_ff;
        if (wr_np_tx)
        begin
            nxt_np_more = mgmt_wdata_i[anpr_pkg::BIT_NP];
            nxt_np_msg = mgmt_wdata_i[anpr_pkg::BIT_MSG_PAGE];
            nxt_np_ack2 = mgmt_wdata_i[anpr_pkg::BIT_ACK2];
            nxt_np_code = mgmt_wdata_i[anpr_pkg::BIT_CODE_HI:0];
        end
        if (np_tx_sent_i && NEXT_PAGE_EN)
        begin
            nxt_np_toggle = ~np_toggle_ff;
        end
    end

    // A page arriving in the cycle of an expansion read keeps the flag set.
    always_comb
    begin
        nxt_page_rx = page_rx_ff;
        if (mgmt_rd_i && (mgmt_addr_i == anpr_pkg::ADDR_EXPANSION))
        begin
            nxt_page_rx = 1'b0;
        end
        if (base_load_i || np_rx_load_i)
        begin
            nxt_page_rx = 1'b1;
        end
    end

    always_comb
    begin
        np_tx_word = '0;
        np_tx_word[anpr_pkg::BIT_NP] = np_more_ff;
        np_tx_word[anpr_pkg::BIT_MSG_PAGE] = np_msg_ff;
        np_tx_word[anpr_pkg::BIT_ACK2] = np_ack2_ff;
        np_tx_word[anpr_pkg::BIT_TOGGLE] = np_toggle_ff;
        np_tx_word[anpr_pkg::BIT_CODE_HI:0] = np_code_ff;
    end

    // Read data is registered; it reflects state before the read's own clear.
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (mgmt_rd_i)
        begin
            nxt_rdata = '0;
            unique case (mgmt_addr_i)
                anpr_pkg::ADDR_ADVERT:
                begin
                    nxt_rdata[anpr_pkg::BIT_NP] = 1'b0;
                    nxt_rdata[anpr_pkg::BIT_RF_HI:anpr_pkg::BIT_RF_LO] = advert_ff.remote_fault;
                    nxt_rdata[anpr_pkg::BIT_PAUSE_HI:anpr_pkg::BIT_PAUSE_LO] = advert_ff.pause;
                    nxt_rdata[anpr_pkg::BIT_HD] = 1'b0;
                    nxt_rdata[anpr_pkg::BIT_FD] = advert_ff.full_duplex;
                end
                anpr_pkg::ADDR_PARTNER:
                begin
                    nxt_rdata = partner_word;
                end
                anpr_pkg::ADDR_EXPANSION:
                begin
                    nxt_rdata[anpr_pkg::BIT_NP_ABLE] = anpr_pkg::NP_ABLE_VALUE;
                    nxt_rdata[anpr_pkg::BIT_PAGE_RX] = page_rx_ff;
                end
                anpr_pkg::ADDR_NP_TX:
                begin
                    nxt_rdata = np_tx_word;
                end
                anpr_pkg::ADDR_NP_RX:
                begin
                    nxt_rdata = np_rx_word;
                end
                default:
                begin
                    nxt_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            advert_ff <= '{remote_fault: anpr_pkg::RF_NO_ERROR, pause: anpr_pkg::RST_PAUSE,
                           full_duplex: anpr_pkg::RST_FD};
            np_more_ff <= anpr_pkg::RST_NP_MORE;
            np_msg_ff <= anpr_pkg::RST_MSG_PAGE;
            np_ack2_ff <= anpr_pkg::RST_ACK2;
            np_code_ff <= anpr_pkg::RST_CODE;
            np_toggle_ff <= 1'b0;
            page_rx_ff <= 1'b0;
            rdata_ff <= '0;
        end
        else
        begin
            advert_ff <= nxt_advert;
            np_more_ff <= nxt_np_more;
            np_msg_ff <= nxt_np_msg;
            np_ack2_ff <= nxt_np_ack2;
            np_code_ff <= nxt_np_code;
            np_toggle_ff <= nxt_np_toggle;
            page_rx_ff <= nxt_page_rx;
            rdata_ff <= nxt_rdata;
        end
    end

    assign mgmt_rdata_o = rdata_ff;
    assign advert_o = advert_ff;

    always_comb
    begin
        np_tx_page_o = '0;
        np_tx_page_o.more = np_more_ff;
        np_tx_page_o.msg_page = np_msg_ff;
        np_tx_page_o.ack2 = np_ack2_ff;
        np_tx_page_o.toggle = np_toggle_ff;
        np_tx_page_o.code = np_code_ff;
    end

endmodule

// ===== testbench/anpr_regs_asserts.sv
/* Port checker for the auto-negotiation page register bank.
   Assumes it is bound to anpr_regs and sees only its ports. */
`timescale 1ns/1ps
module anpr_regs_asserts #(
    parameter bit NEXT_PAGE_EN = 1'b0
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic mgmt_rd_i,
    input wire logic [4:0] mgmt_addr_i,
    input wire logic [15:0] mgmt_rdata_o,
    input wire logic an_complete_i,
    input wire logic base_load_i,
    input wire logic np_rx_load_i,
    input wire anpr_pkg::anpr_advert_t advert_o,
    input wire anpr_pkg::anpr_npage_t np_tx_page_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    logic rd4;
    logic rd6;
    assign rd4 = mgmt_rd_i && mgmt_addr_i == 5'h04;
    assign rd6 = mgmt_rd_i && mgmt_addr_i == 5'h06;
    adv_np_zero_a: assert property (rd4 |=> !mgmt_rdata_o[15]) else $error("next page bit set");
    adv_hd_zero_a: assert property (rd4 |=> !mgmt_rdata_o[6]) else $error("half duplex bit set");
    adv_rsvd_a: assert property (rd4 |=> (mgmt_rdata_o & 16'h4E1F) == 16'h0000)
        else $error("reserved advert bits set");
    adv_read_a: assert property (rd4 |=> mgmt_rdata_o[13:5] == {$past(advert_o.remote_fault), 3'h0,
        $past(advert_o.pause), 1'b0, $past(advert_o.full_duplex)}) else $error("advert read mismatch");
    rf_clear_a: assert property (an_complete_i |=> advert_o.remote_fault == 2'h0)
        else $error("remote fault not cleared");
    exp_fixed_a: assert property (rd6 |=> mgmt_rdata_o[2] && (mgmt_rdata_o & 16'hFFF9) == 16'h0000)
        else $error("expansion fixed bits wrong");
    flag_set_a: assert property ((base_load_i || np_rx_load_i) ##1 rd6 |=> mgmt_rdata_o[1])
        else $error("page flag not set");
    flag_clear_a: assert property (rd6 && !(base_load_i || np_rx_load_i) ##1 rd6 |=> !mgmt_rdata_o[1])
        else $error("page flag not cleared");
    undef_zero_a: assert property (mgmt_rd_i && (mgmt_addr_i < 5'h04 || mgmt_addr_i > 5'h08)
        |=> mgmt_rdata_o == 16'h0000) else $error("undefined read not zero");
    np_tx_dflt_a: assert property (!NEXT_PAGE_EN |-> np_tx_page_o == 16'h2001)
        else $error("next page tx not default");
    cover property (base_load_i ##1 rd6);
    cover property (an_complete_i);
    cover property (rd6 ##1 rd6);
endmodule

bind anpr_regs anpr_regs_asserts #(.NEXT_PAGE_EN(NEXT_PAGE_EN)) u_anpr_regs_asserts (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .mgmt_rd_i(mgmt_rd_i),
    .mgmt_addr_i(mgmt_addr_i),
    .mgmt_rdata_o(mgmt_rdata_o),
    .an_complete_i(an_complete_i),
    .base_load_i(base_load_i),
    .np_rx_load_i(np_rx_load_i),
    .advert_o(advert_o),
    .np_tx_page_o(np_tx_page_o)
);

// ===== testbench/anpr_an_model.sv
/* Behavioural negotiation function: delivers pages and events.
   Assumes it shares core_clk_i with the register bank. */
`timescale 1ns/1ps
module anpr_an_model (
    input wire logic core_clk_i,
    output logic an_complete_o,
    output logic base_load_o,
    output anpr_pkg::anpr_base_t base_page_o,
    output logic np_rx_load_o,
    output anpr_pkg::anpr_npage_t np_rx_page_o,
    output logic np_tx_sent_o
);
    initial
    begin
        an_complete_o = 1'b0;
        base_load_o = 1'b0;
        base_page_o = 8'h00;
        np_rx_load_o = 1'b0;
        np_rx_page_o = 16'h0000;
        np_tx_sent_o = 1'b0;
    end
    // Pages after a load pulse are inverted so a late capture shows up as wrong data.
    task automatic send_base(input anpr_pkg::anpr_base_t p);
        @(posedge core_clk_i);
        base_load_o <= 1'b1;
        base_page_o <= p;
        @(posedge core_clk_i);
        base_load_o <= 1'b0;
        base_page_o <= ~p;
    endtask
    task automatic send_np(input anpr_pkg::anpr_npage_t p);
        @(posedge core_clk_i);
        np_rx_load_o <= 1'b1;
        np_rx_page_o <= p;
        @(posedge core_clk_i);
        np_rx_load_o <= 1'b0;
        np_rx_page_o <= ~p;
    endtask
    task automatic finish_events();
        @(posedge core_clk_i);
        an_complete_o <= 1'b1;
        np_tx_sent_o <= 1'b1;
        @(posedge core_clk_i);
        an_complete_o <= 1'b0;
        np_tx_sent_o <= 1'b0;
    endtask
endmodule

// ===== testbench/anpr_regs_tb.sv
/* Self-checking bench for anpr_regs with the negotiation model.
   Assumes the main copy has next page support disabled and a second copy has it enabled. */
`timescale 1ns/1ps
module anpr_regs_tb;
    logic core_clk_i;
    logic rst_i = 1'b1;
    logic mgmt_wr_i = 1'b0;
    logic mgmt_rd_i = 1'b0;
    logic cfg_load_i = 1'b0;
    logic an_complete_i, base_load_i, np_rx_load_i, np_tx_sent_i;
    logic [4:0] mgmt_addr_i = 5'h00;
    logic [15:0] mgmt_wdata_i = 16'h0000;
    logic [15:0] mgmt_rdata_o;
    anpr_pkg::anpr_advert_t cfg_advert_i = 5'h00;
    anpr_pkg::anpr_advert_t advert_o;
    anpr_pkg::anpr_base_t base_page_i;
    anpr_pkg::anpr_npage_t np_rx_page_i, np_tx_page_o;
    logic [15:0] np_rdata;
    anpr_pkg::anpr_advert_t np_advert;
    anpr_pkg::anpr_npage_t np_tx_page_np;
    int fails = 0;
    int check_count = 0;
    anpr_regs #(.NEXT_PAGE_EN(1'b0)) u_anpr_regs (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .mgmt_wr_i(mgmt_wr_i), .mgmt_rd_i(mgmt_rd_i), .mgmt_addr_i(mgmt_addr_i),
        .mgmt_wdata_i(mgmt_wdata_i), .mgmt_rdata_o(mgmt_rdata_o), .cfg_load_i(cfg_load_i),
        .cfg_advert_i(cfg_advert_i), .an_complete_i(an_complete_i), .base_load_i(base_load_i),
        .base_page_i(base_page_i), .np_rx_load_i(np_rx_load_i), .np_rx_page_i(np_rx_page_i),
        .np_tx_sent_i(np_tx_sent_i), .advert_o(advert_o), .np_tx_page_o(np_tx_page_o));
    // A second copy with next page support built in, so the transmit page write and toggle paths run.
    anpr_regs #(.NEXT_PAGE_EN(1'b1)) u_anpr_regs_np (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .mgmt_wr_i(mgmt_wr_i), .mgmt_rd_i(mgmt_rd_i), .mgmt_addr_i(mgmt_addr_i),
        .mgmt_wdata_i(mgmt_wdata_i), .mgmt_rdata_o(np_rdata), .cfg_load_i(cfg_load_i),
        .cfg_advert_i(cfg_advert_i), .an_complete_i(an_complete_i), .base_load_i(base_load_i),
        .base_page_i(base_page_i), .np_rx_load_i(np_rx_load_i), .np_rx_page_i(np_rx_page_i),
        .np_tx_sent_i(np_tx_sent_i), .advert_o(np_advert), .np_tx_page_o(np_tx_page_np));
    anpr_an_model u_anpr_an_model (.core_clk_i(core_clk_i), .an_complete_o(an_complete_i),
        .base_load_o(base_load_i), .base_page_o(base_page_i), .np_rx_load_o(np_rx_load_i),
        .np_rx_page_o(np_rx_page_i), .np_tx_sent_o(np_tx_sent_i));
    initial
    begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        mgmt_wr_i <= 1'b1;
        mgmt_addr_i <= a;
        mgmt_wdata_i <= d;
        @(posedge core_clk_i);
        mgmt_wr_i <= 1'b0;
        mgmt_wdata_i <= ~d;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        @(posedge core_clk_i);
        mgmt_rd_i <= 1'b1;
        mgmt_addr_i <= a;
        @(posedge core_clk_i);
        mgmt_rd_i <= 1'b0;
        @(posedge core_clk_i);
        check(mgmt_rdata_o, exp);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic t_defaults();
        rd_chk(5'h04, 16'h01A0);
        rd_chk(5'h05, 16'h0000);
        rd_chk(5'h06, 16'h0004);
        rd_chk(5'h07, 16'h2001);
        rd_chk(5'h08, 16'h0000);
        check(16'(advert_o), 16'h0007);
        $display("defaults done");
    endtask
    task automatic t_advert();
        wr(5'h04, 16'hFFFF);
        rd_chk(5'h04, 16'h31A0);
        for (int i = 0; i < 4; i++)
        begin
            wr(5'h04, {2'h0, 2'(i), 12'h000});
            rd_chk(5'h04, {2'h0, 2'(i), 12'h000});
        end
        u_anpr_an_model.finish_events();
        rd_chk(5'h04, 16'h0000);
        cfg_advert_i <= 5'h12;
        cfg_load_i <= 1'b1;
        @(posedge core_clk_i);
        cfg_load_i <= 1'b0;
        rd_chk(5'h04, 16'h2080);
        $display("advert done");
    endtask
    task automatic t_pages();
        u_anpr_an_model.send_base(8'hE7);
        wr(5'h05, 16'h0000);
        rd_chk(5'h05, 16'hE0E0);
        @(posedge core_clk_i);
        mgmt_rd_i <= 1'b1;
        mgmt_addr_i <= 5'h06;
        @(posedge core_clk_i);
        @(negedge core_clk_i);
        check(mgmt_rdata_o, 16'h0006);
        @(posedge core_clk_i);
        mgmt_rd_i <= 1'b0;
        @(posedge core_clk_i);
        check(mgmt_rdata_o, 16'h0004);
        u_anpr_an_model.send_np(16'hFDA5);
        wr(5'h08, 16'h0000);
        wr(5'h06, 16'hFFFF);
        rd_chk(5'h08, 16'hFDA5);
        rd_chk(5'h06, 16'h0006);
        wr(5'h07, 16'h9FFF);
        rd_chk(5'h07, 16'h2001);
        check(16'(np_tx_page_o), 16'h2001);
        $display("pages done");
    endtask
    task automatic t_np_enabled();
        check(16'(np_tx_page_np), 16'h9FFF);
        wr(5'h07, 16'h2155);
        rd_chk(5'h07, 16'h2001);
        check(np_rdata, 16'h2955);
        check(16'(np_tx_page_np), 16'h2955);
        u_anpr_an_model.finish_events();
        rd_chk(5'h07, 16'h2001);
        check(np_rdata, 16'h2155);
        check(16'(np_advert), 16'h0002);
        check(16'(advert_o), 16'h0002);
        $display("next page done");
    endtask
    task automatic t_undef();
        logic [4:0] addrs [4] = '{5'h00, 5'h03, 5'h09, 5'h1F};
        foreach (addrs[i])
        begin
            wr(addrs[i], 16'hFFFF);
            rd_chk(addrs[i], 16'h0000);
        end
        $display("undefined done");
    endtask
    initial
    begin
        repeat (16) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_defaults();
        t_advert();
        t_pages();
        t_np_enabled();
        t_undef();
        wrap_up();
    end
    initial
    begin
        repeat (5000) @(posedge core_clk_i);
        fails++;
        wrap_up();
    end
endmodule
